// *** logic/adci_map.vh ***
/*
  Constants of the converter's two-wire slave port: APB offsets, field
  positions, reset values and timing counts.
  Assumes a 25 MHz pclk and a 32-bit APB master.
*/
`ifndef ADCI_MAP_VH
`define ADCI_MAP_VH

// Clock and timing
`define ADCI_CLK_MHZ          25
`define ADCI_POR_TIME_US      4000
`define ADCI_POR_CYCLES       (`ADCI_POR_TIME_US * `ADCI_CLK_MHZ)
`define ADCI_CONV_CYCLES      16'h0FA0

// APB byte offsets
`define ADCI_OFS_STAGE        8'h00
`define ADCI_OFS_RESULT       8'h04
`define ADCI_OFS_CONFIG       8'h08
`define ADCI_OFS_STATUS       8'h0C

// Config fields
`define ADCI_CHAN_W           5
`define ADCI_CHAN_RST         5'h00
`define ADCI_MODE_RST         8'h00
`define ADCI_PREFIX_TAKE      3'h5
`define ADCI_PREFIX_LSB       5

// Status bit positions
`define ADCI_ST_BUSY          0
`define ADCI_ST_POR           1
`define ADCI_ST_SEL           2
`define ADCI_ST_ADDR_LSB      8

// Address straps
`define ADCI_ADDR_COUNT       27
`define ADCI_ADDR_BASE        7'h10

`endif

// *** logic/adci_addr_rom.v ***
/*
  Lookup of the device's own bus address from the strap index.
  Assumes the index is stable; the answer comes out of a register.
*/
`timescale 1ns/10ps
`include "adci_map.vh"

module adci_addr_rom (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [4:0] idx,
  output reg  [6:0] addr_q
);

  // Base value is arbitrary; one address per strap combination
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 7'h00;
    end else if (idx < `ADCI_ADDR_COUNT) begin
      addr_q <= `ADCI_ADDR_BASE + {2'h0, idx};
    end else begin
      addr_q <= `ADCI_ADDR_BASE;
    end
  end

endmodule

// *** logic/adci_slave.v ***
/*
  Two-wire slave port of a delta-sigma converter, with power-on reset,
  conversion timing and an APB window for the converter core.
  Assumes scl, sda and strap pins are asynchronous to pclk; the wire
  level of sda is resolved outside from sda_oe.
*/
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "adci_map.vh"

module adci_slave #(
  parameter integer POR_CYCLES = `ADCI_POR_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  input  wire        scl,
  input  wire        sda_i,
  output reg         sda_o_q,
  output reg         sda_oe_q,
  input  wire [5:0]  ca_code
);

  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_ADDR = 8'h02;
  localparam [7:0] S_AACK = 8'h04;
  localparam [7:0] S_WR   = 8'h08;
  localparam [7:0] S_WACK = 8'h10;
  localparam [7:0] S_RD   = 8'h20;
  localparam [7:0] S_MACK = 8'h40;
  localparam [7:0] S_IGN  = 8'h80;
  reg  [16:0] por_cnt_q;
  reg         por_act_q;
  reg         por_done_q;
  reg  [2:0]  scl_s_q;
  reg  [2:0]  sda_s_q;
  reg  [5:0]  ca_s1_q;
  reg  [5:0]  ca_s2_q;
  reg  [4:0]  strap_idx_q;
  wire [6:0]  own_addr;
  reg  [7:0]  st_q;
  reg  [3:0]  cnt_q;
  reg  [1:0]  byte_q;
  reg  [7:0]  sh_q;
  reg  [23:0] out_q;
  reg         rw_q;
  reg         mack_q;
  reg         wr_ok_q;
  reg         rd_part_q;
  reg  [2:0]  prefix_q;
  reg  [4:0]  chan_q;
  reg  [7:0]  mode_q;
  reg         go_q;
  reg         busy_q;
  reg  [15:0] tmr_q;
  reg  [12:0] applied_q;
  reg  [23:0] stage_q;
  reg  [23:0] result_q;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_ev;
  wire        stop_ev;
  wire        apb_setup;
  wire        hit;

  // Power-on reset timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_q  <= 17'h00000;
      por_act_q  <= 1'b1;
      por_done_q <= 1'b0;
    end else if (por_act_q) begin
      por_cnt_q  <= por_cnt_q + 17'h00001;
      por_act_q  <= (por_cnt_q != POR_CYCLES[16:0] - 17'h00001);
      por_done_q <= (por_cnt_q == POR_CYCLES[16:0] - 17'h00001);
    end else begin
      por_done_q <= 1'b0;
    end
  end

  // Pin synchronisers; stage 1 feeds stage 2 only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      ca_s1_q <= 6'h00;
      ca_s2_q <= 6'h00;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      ca_s1_q <= ca_code;
      ca_s2_q <= ca_s1_q;
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
  assign start_ev = scl_s_q[1] & scl_s_q[2] & sda_s_q[2] & ~sda_s_q[1];
  assign stop_ev  = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[2] & sda_s_q[1];

  // Strap index caught while power-on reset runs: code 0 low, 1 high, else float
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_idx_q <= 5'h00;
    end else if (por_act_q) begin
      strap_idx_q <= {3'h0, (ca_s2_q[1] ? 2'h2 : {1'b0, ca_s2_q[0]})}
                   + 5'h03 * {3'h0, (ca_s2_q[3] ? 2'h2 : {1'b0, ca_s2_q[2]})}
                   + 5'h09 * {3'h0, (ca_s2_q[5] ? 2'h2 : {1'b0, ca_s2_q[4]})};
    end
  end
  adci_addr_rom u_rom (
    .pclk    (pclk),
    .presetn (presetn),
    .idx     (strap_idx_q),
    .addr_q  (own_addr)
  );

  // Bus slave engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= S_IDLE;
      cnt_q     <= 4'h0;
      byte_q    <= 2'h0;
      sh_q      <= 8'h00;
      out_q     <= 24'h000000;
      rw_q      <= 1'b0;
      mack_q    <= 1'b0;
      wr_ok_q   <= 1'b0;
      rd_part_q <= 1'b0;
      prefix_q  <= 3'h0;
      chan_q    <= `ADCI_CHAN_RST;
      mode_q    <= `ADCI_MODE_RST;
      go_q      <= 1'b0;
      sda_o_q   <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (!por_act_q) begin
      go_q    <= 1'b0;
      if (start_ev) begin
        st_q     <= S_ADDR;
        cnt_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_ev) begin
        st_q      <= S_IDLE;
        sda_oe_q  <= 1'b0;
        go_q      <= wr_ok_q | rd_part_q;
        wr_ok_q   <= 1'b0;
        rd_part_q <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s_q[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              if (sh_q[7:1] != own_addr) begin
                st_q <= S_IGN;
              end else if (busy_q) begin
                st_q <= S_IGN;
              end else begin
                st_q     <= S_AACK;
                sda_oe_q <= 1'b1;
                rw_q     <= sh_q[0];
                out_q    <= result_q;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              byte_q <= 2'h0;
              if (rw_q) begin
                st_q      <= S_RD;
                cnt_q     <= 4'h1;
                rd_part_q <= 1'b1;
                sda_oe_q  <= ~out_q[23];
                out_q     <= {out_q[22:0], 1'b0};
              end else begin
                st_q     <= S_WR;
                cnt_q    <= 4'h0;
                wr_ok_q  <= 1'b1;
                sda_oe_q <= 1'b0;
              end
            end
          end
          S_WR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s_q[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              st_q     <= S_WACK;
              sda_oe_q <= 1'b1;
              if (byte_q != 2'h3) begin
                byte_q <= byte_q + 2'h1;
              end
              if (byte_q == 2'h0) begin
                prefix_q <= sh_q[7:`ADCI_PREFIX_LSB];
                if (sh_q[7:`ADCI_PREFIX_LSB] == `ADCI_PREFIX_TAKE) begin
                  chan_q <= sh_q[4:0];
                end
              end else if (byte_q == 2'h1 && prefix_q == `ADCI_PREFIX_TAKE) begin
                mode_q <= sh_q;
              end
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              st_q     <= S_WR;
              cnt_q    <= 4'h0;
              sda_oe_q <= 1'b0;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                st_q     <= S_MACK;
                sda_oe_q <= 1'b0;
                byte_q   <= byte_q + 2'h1;
                if (byte_q == 2'h2) begin
                  go_q      <= 1'b1;
                  rd_part_q <= 1'b0;
                end
              end else begin
                cnt_q    <= cnt_q + 4'h1;
                sda_oe_q <= ~out_q[23];
                out_q    <= {out_q[22:0], 1'b0};
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s_q[1];
            end else if (scl_fall) begin
              if (mack_q && byte_q != 2'h3) begin
                st_q     <= S_RD;
                cnt_q    <= 4'h1;
                sda_oe_q <= ~out_q[23];
                out_q    <= {out_q[22:0], 1'b0};
              end else begin
                st_q <= S_IGN;
              end
            end
          end
          S_IDLE, S_IGN: sda_oe_q <= 1'b0;
          default: begin
            st_q     <= S_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Conversion timer; result latched from the staging word at the end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q    <= 1'b0;
      tmr_q     <= 16'h0000;
      applied_q <= 13'h0000;
      result_q  <= 24'h000000;
    end else if (go_q || por_done_q) begin
      busy_q    <= 1'b1;
      tmr_q     <= 16'h0000;
      applied_q <= {mode_q, chan_q};
    end else if (busy_q) begin
      if (tmr_q == `ADCI_CONV_CYCLES - 16'h0001) begin
        busy_q   <= 1'b0;
        result_q <= stage_q;
      end else begin
        tmr_q <= tmr_q + 16'h0001;
      end
    end
  end

  // APB slave: one wait-free answer, pready registered from the setup cycle and high in the access cycle
  assign apb_setup = psel & ~penable & ~pready_q;
  assign hit       = (paddr == `ADCI_OFS_STAGE) | (paddr == `ADCI_OFS_RESULT) |
                     (paddr == `ADCI_OFS_CONFIG) | (paddr == `ADCI_OFS_STATUS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      stage_q   <= 24'h000000;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~hit;
      if (!por_act_q && psel && penable && pready_q && pwrite && paddr == `ADCI_OFS_STAGE) begin
        stage_q <= pwdata[23:0];
      end
      if (apb_setup && !pwrite) begin
        case (paddr)
          `ADCI_OFS_STAGE:  prdata_q <= {8'h00, stage_q};
          `ADCI_OFS_RESULT: prdata_q <= {8'h00, result_q};
          `ADCI_OFS_CONFIG: prdata_q <= {3'h0, applied_q, 3'h0, mode_q, chan_q};
          `ADCI_OFS_STATUS: prdata_q <= {17'h00000, own_addr, 5'h00,
                                         (st_q != S_IDLE && st_q != S_IGN), por_act_q, busy_q};
          default:          prdata_q <= 32'h00000000;
        endcase
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

endmodule

// *** testbench/adci_slave_chk.sv ***
/* Assertions on the slave port's pins and APB answers.
   Bound to adci_slave; sees only its ports. */
`timescale 1ns/10ps
module adci_slave_chk #(
  parameter integer POR_CYCLES = 100000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata_q,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  input wire logic        scl,
  input wire logic        sda_o_q,
  input wire logic        sda_oe_q
);
  localparam int QUIET = POR_CYCLES + 4000;
  logic [31:0] cnt_q;
  // Cycles since reset release, saturating
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 32'h0;
    else if (cnt_q < QUIET) cnt_q <= cnt_q + 32'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sda_low_a: assert property (sda_o_q == 1'b0) else $error("data driven high");
  setup_rdy_a: assert property (psel && !penable |=> pready_q) else $error("no ready after setup");
  rdy_pulse_a: assert property (pready_q |=> !pready_q) else $error("ready too long");
  err_map_a: assert property (pready_q |-> pslverr_q == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0))
    else $error("wrong slave error");
  err_data_a: assert property (pslverr_q |-> pready_q && prdata_q == 32'h0) else $error("bad error answer");
  idle_data_a: assert property (!pready_q |-> prdata_q == 32'h0) else $error("data outside access");
  por_quiet_a: assert property (cnt_q < QUIET |-> !sda_oe_q) else $error("ack too early");
  oe_rise_a: assert property ($rose(sda_oe_q) |-> !scl) else $error("pull while clock high");
endmodule

// *** testbench/adci_bus_master.sv ***
/* Behavioural two-wire bus master: clock and data pull-down.
   Assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/10ps
module adci_bus_master (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_in
);
  localparam int QTR = 80;
  event       rx_e;
  logic [8:0] rx_d;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Pins change by non-blocking assignment: steps fall on pclk edges
  task automatic put_bit(input logic b);
    sda_pull <= !b;
    #QTR scl <= 1'b1;
    #(2*QTR) scl <= 1'b0;
    #QTR;
  endtask
  task automatic get_bit(output logic b);
    sda_pull <= 1'b0;
    #QTR scl <= 1'b1;
    #QTR b = sda_in;
    #QTR scl <= 1'b0;
    #QTR;
  endtask
  task automatic start();
    sda_pull <= 1'b0;
    #QTR scl <= 1'b1;
    #QTR sda_pull <= 1'b1;
    #QTR scl <= 1'b0;
    #QTR;
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    #QTR scl <= 1'b1;
    #QTR sda_pull <= 1'b0;
    #(2*QTR);
  endtask
  task automatic send(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(a);
    rx_d = {8'h00, a};
    ->rx_e;
  endtask
  task automatic recv(input logic nak);
    logic [7:0] b;
    for (int i = 7; i >= 0; i--) get_bit(b[i]);
    put_bit(nak);
    rx_d = {b, 1'b0};
    ->rx_e;
  endtask
endmodule

// *** testbench/adci_slave_test.sv ***
/* Self-checking bench for adci_slave: APB driver, two-wire master model,
   queued expectations checked by monitors. POR shortened to 50 cycles. */
`timescale 1ns/10ps
module adci_slave_test;
  localparam int POR = 50;
  localparam int CONV = 4100;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, md;
  logic [31:0] pwdata, prdata_q;
  logic        pready_q, pslverr_q, sda_o_q, sda_oe_q, scl, m_pull;
  logic [5:0]  ca_code;
  logic [6:0]  own;
  logic [23:0] stg;
  logic [4:0]  ch;
  logic [32:0] apb_q[$];
  logic [8:0]  bus_q[$];
  int          err_total, tests_run;
  wire         sda_w = !((sda_oe_q && !sda_o_q) || m_pull);
  adci_slave #(.POR_CYCLES(POR)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .scl(scl), .sda_i(sda_w), .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q),
    .ca_code(ca_code));
  adci_bus_master m (.scl(scl), .sda_pull(m_pull), .sda_in(sda_w));
  always #20 pclk = !pclk;
  task automatic bad(input string s);
    err_total++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task automatic chk_apb(input logic [32:0] v);
    tests_run++;
    if (apb_q.size() == 0) bad("unexpected apb read");
    else if (v !== apb_q[0]) bad($sformatf("apb got %h want %h", v, apb_q[0]));
    if (apb_q.size() != 0) apb_q.pop_front();
  endtask
  task automatic chk_bus(input logic [8:0] v);
    tests_run++;
    if (bus_q.size() == 0) bad("unexpected bus result");
    else if (v !== bus_q[0]) bad($sformatf("bus got %h want %h", v, bus_q[0]));
    if (bus_q.size() != 0) bus_q.pop_front();
  endtask
  always @(posedge pclk)
    if (psel && penable && pready_q === 1'b1 && !pwrite) chk_apb({pslverr_q, prdata_q});
  always @(m.rx_e) chk_bus(m.rx_d);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_q !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tx(input logic [7:0] b, input logic ack);
    bus_q.push_back({8'h00, ack});
    m.send(b);
  endtask
  task automatic rx(input logic [7:0] e, input logic nak);
    bus_q.push_back({e, 1'b0});
    m.recv(nak);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    err_total++;
    finish_test();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(69962));
    for (int i = 0; i < 3; i++) ca_code[2*i +: 2] = 2'($urandom % 3);
    own = 7'h10 + 7'(ca_code[1:0] + 3 * ca_code[3:2] + 9 * ca_code[5:4]);
    stg = 24'($urandom);
    ch = 5'($urandom);
    md = 8'($urandom);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04, 33'h0);
    rd(8'h08, 33'h0);
    m.start();
    tx({own, 1'b0}, 1'b1);
    m.stop();
    repeat (CONV) @(posedge pclk);
    rd(8'h0C, {18'h0, own, 8'h00});
    apb(1'b1, 8'h00, {8'h00, stg});
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    rd(8'h10, {1'b1, 32'h0});
    rd(8'h00, {9'h0, stg});
    m.start();
    tx({own ^ 7'h01, 1'b0}, 1'b1);
    tx(8'hA0, 1'b1);
    m.start();
    tx({own, 1'b0}, 1'b0);
    tx({3'b101, ch}, 1'b0);
    tx(md, 1'b0);
    m.stop();
    rd(8'h08, {4'h0, md, ch, 3'h0, md, ch});
    rd(8'h0C, {18'h0, own, 8'h01});
    m.start();
    tx({own, 1'b1}, 1'b1);
    m.stop();
    repeat (CONV) @(posedge pclk);
    rd(8'h04, {9'h0, stg});
    m.start();
    tx({own, 1'b1}, 1'b0);
    rx(stg[23:16], 1'b0);
    rx(stg[15:8], 1'b0);
    rx(stg[7:0], 1'b1);
    m.start();
    tx({own, 1'b1}, 1'b1);
    m.stop();
    repeat (CONV) @(posedge pclk);
    m.start();
    tx({own, 1'b0}, 1'b0);
    tx(8'h1F, 1'b0);
    m.stop();
    rd(8'h08, {4'h0, md, ch, 3'h0, md, ch});
    rd(8'h0C, {18'h0, own, 8'h01});
    repeat (CONV) @(posedge pclk);
    m.start();
    tx({own, 1'b1}, 1'b0);
    rx(stg[23:16], 1'b1);
    m.stop();
    rd(8'h0C, {18'h0, own, 8'h01});
    repeat (4) @(posedge pclk);
    finish_test();
  end
endmodule
bind adci_slave adci_slave_chk #(.POR_CYCLES(POR_CYCLES)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata_q(prdata_q), .pready_q(pready_q),
  .pslverr_q(pslverr_q), .scl(scl), .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q));
